// file: dv/lctm_host_model.sv
// Host-side model of the link: clock, line state and HS framing
`timescale 1ns/1ps
`default_nettype none
module lctm_host_model (
    output var logic       o_link_clk,
    output var logic [1:0] o_lp_line,
    output var logic       o_hs_active,
    output var logic       o_eot
);
    // ========================================================
    // Idle is the stop state; link clock stands still outside frames
    initial begin
        o_link_clk = 1'b0;
        o_lp_line = 2'h3;
        o_hs_active = 1'b0;
        o_eot = 1'b0;
    end
    // own HS length, EoT, then stop
    task automatic hs_burst(input int n);
        o_lp_line = 2'h1;
        #400 o_lp_line = 2'h0;
        o_hs_active = 1'b1;
        repeat (2 * n) #400 o_link_clk = ~o_link_clk;
        o_eot = 1'b1;
        #400 o_hs_active = 1'b0;
        o_eot = 1'b0;
        #400 o_lp_line = 2'h3;
    endtask
    // host drives line, stop state to recover
    task automatic drive(input logic [1:0] v);
        o_lp_line = v;
    endtask
endmodule
`default_nettype wire

// file: dv/lctm_monitor_chk.sv
// Port checker for the contention and timeout monitor
`timescale 1ns/1ps
`default_nettype none
module lctm_monitor_chk (
    input wire logic                       i_clk,
    input wire logic                       i_rst,
    input wire logic                       i_bidir,
    input wire logic                       i_escape_en,
    input wire logic                       i_err_sot,
    input wire logic                       i_err_esc,
    input wire logic                       i_err_clear,
    input wire logic                       o_lp_tx_grant,
    input wire logic                       o_hs_rx_err,
    input wire logic                       o_ignore_bus,
    input wire logic [lctm_pkg::ERR_W-1:0] o_err_flags,
    input wire logic [lctm_pkg::ERR_W-1:0] o_err_report
);
    // ========================================================
    // Assertions; one clock domain only
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    hs_pulse_a: assert property (o_hs_rx_err |=> !o_hs_rx_err)
        else $error("expiry pulse longer than one cycle");
    hs_ignore_a: assert property (o_hs_rx_err |-> ##[0:1] o_ignore_bus)
        else $error("bus not ignored after expiry");
    hrx_flag_a: assert property ($rose(o_err_flags[6]) |-> !o_ignore_bus
        && ($past(o_ignore_bus) || $past(o_ignore_bus, 2))) else $error("hs flag not at stop");
    ltx_flag_a: assert property ($rose(o_err_flags[7]) |-> !o_ignore_bus
        && ($past(o_ignore_bus) || $past(o_ignore_bus, 2))) else $error("lp flag not at stop");
    grant_gate_a: assert property (o_lp_tx_grant |-> i_bidir && !o_ignore_bus)
        else $error("grant while unidirectional or ignoring");
    report_gate_a: assert property (o_err_report
        == ($past(i_escape_en) ? o_err_flags : 10'h000)) else $error("report mismatch");
    sot_set_a: assert property (i_err_sot |=> o_err_flags[0])
        else $error("start error not flagged");
    esc_gate_a: assert property (i_err_esc && !i_escape_en && !o_err_flags[3]
        |=> !o_err_flags[3]) else $error("escape error flagged without escape mode");
    flag_sticky_a: assert property (!$past(i_err_clear)
        |-> (o_err_flags & $past(o_err_flags)) == $past(o_err_flags)) else $error("flag lost");
    cont_bidir_a: assert property ($rose(o_err_flags[8]) |-> $past(i_bidir))
        else $error("contention on unidirectional lane");
    cover property (o_hs_rx_err);
    cover property ($rose(o_err_flags[7]));
    cover property ($rose(o_err_flags[9]));
endmodule
bind lctm_monitor lctm_monitor_chk i_chk (.i_clk(i_clk), .i_rst(i_rst), .i_bidir(i_bidir),
    .i_escape_en(i_escape_en), .i_err_sot(i_err_sot), .i_err_esc(i_err_esc),
    .i_err_clear(i_err_clear), .o_lp_tx_grant(o_lp_tx_grant), .o_hs_rx_err(o_hs_rx_err),
    .o_ignore_bus(o_ignore_bus), .o_err_flags(o_err_flags), .o_err_report(o_err_report));
`default_nettype wire

// file: dv/test_lctm_monitor.sv
// Self-checking bench for the contention and timeout monitor
`timescale 1ns/1ps
`default_nettype none
module test_lctm_monitor;
    localparam int HRX = 40;
    localparam int LTX = 30;
    logic       clk = 1'b0, rst = 1'b1, bidir = 1'b1, esc = 1'b1, req = 1'b0, clr = 1'b0;
    logic [5:0] errs = 6'h00;
    logic [1:0] drv = 2'h0, line;
    logic [9:0] flags, rep;
    logic [23:0] hrx_lim = 24'(HRX), ltx_lim = 24'(LTX);
    logic       lclk, hsa, eot, grant, hs_err, ign, seen;
    int         n_errors = 0, checked = 0, cyc = 0, n_hs = 0, n_seen = 0;
    lctm_host_model i_host (.o_link_clk(lclk), .o_lp_line(line), .o_hs_active(hsa), .o_eot(eot));
    lctm_monitor i_lctm_monitor (.i_clk(clk), .i_rst(rst), .i_bidir(bidir), .i_escape_en(esc),
        .i_hs_receive_timeout(hrx_lim), .i_lp_transmit_peripheral_timeout(ltx_lim),
        .i_link_clk(lclk), .i_lp_line(line), .i_hs_active(hsa), .i_eot(eot),
        .i_lp_tx_req(req), .i_lp_tx_drive(drv), .i_err_sot(errs[0]), .i_err_sot_sync(errs[1]),
        .i_err_eot_sync(errs[2]), .i_err_esc(errs[3]), .i_err_lp_sync(errs[4]),
        .i_err_false(errs[5]), .i_err_clear(clr), .o_lp_tx_grant(grant), .o_hs_rx_err(hs_err),
        .o_ignore_bus(ign), .o_err_flags(flags), .o_err_report(rep), .o_link_clk_seen(seen));
    // ========================================================
    // Clock, cycle ceiling and event counters
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (hs_err === 1'b1) n_hs++;
        if (seen === 1'b1) n_seen++;
        if (cyc == 5000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string what, input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    // ========================================================
    // Scenarios
    task automatic t_errors(input logic e, input logic [9:0] exp);
        esc = e;
        for (int i = 0; i < 6; i++) begin
            errs = 6'h01 << i;
            tick(1);
        end
        errs = 6'h00;
        tick(1);
        check("flags", flags[5:0], exp);
        check("report", rep, e ? exp : 10'h000);
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(1);
        check("cleared", flags[5:0], 10'h000);
    endtask
    task automatic t_hs_ok(input int n, input logic bd, input logic [23:0] lim);
        bidir = bd;
        hrx_lim = lim;
        i_host.hs_burst(n);
        tick(10);
        check("no expiry", n_hs[9:0], 10'h000);
        check("hs flag", flags[6], 1'b0);
        check("lp receive", ign, 1'b0);
        check("link clock", n_seen != 0, 1'b1);
        bidir = 1'b1;
        hrx_lim = 24'(HRX);
    endtask
    task automatic t_hs_to;
        int k;
        fork
            i_host.hs_burst(8);
            begin
                for (k = 0; k < 200 && hs_err !== 1'b1; k++) tick(1);
                check("expiry time", k >= HRX + 4 && k <= HRX + 12, 1'b1);
                check("still hs", hsa, 1'b1);
                tick(2);
                check("ignoring", ign, 1'b1);
                check("flag waits", flags[6], 1'b0);
            end
        join
        for (k = 0; k < 50 && ign !== 1'b0; k++) tick(1);
        check("hs flag", flags[6], 1'b1);
        check("one pulse", n_hs[9:0], 10'h001);
    endtask
    task automatic t_lp_to(input logic [23:0] lim);
        int k;
        ltx_lim = lim;
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        req = 1'b1;
        drv = 2'h1;
        i_host.drive(2'h1);
        for (k = 0; k < 10 && grant !== 1'b1; k++) tick(1);
        check("grant", grant, 1'b1);
        for (k = 0; k < 200 && grant === 1'b1; k++) tick(1);
        check("lp expiry", k >= lim && k <= lim + 3, 1'b1);
        req = 1'b0;
        drv = 2'h0;
        i_host.drive(2'h0);
        tick(20);
        check("lp ignoring", ign, 1'b1);
        check("lp flag waits", flags[7], 1'b0);
        i_host.drive(2'h3);
        for (k = 0; k < 20 && ign !== 1'b0; k++) tick(1);
        check("lp flag", flags[7], 1'b1);
    endtask
    task automatic t_cont(input logic bd, input logic [9:0] exp);
        bidir = bd;
        req = 1'b1;
        drv = 2'h3;
        i_host.drive(2'h0);
        tick(12);
        check("grant refused", grant, bd);
        drv = 2'h0;
        i_host.drive(2'h3);
        tick(12);
        req = 1'b0;
        tick(2);
        check("contention", flags[9:8], exp);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #10 rst = 1'b0;
        tick(1);
        t_errors(1'b1, 10'h03F);
        t_errors(1'b0, 10'h007);
        t_hs_ok(2, 1'b1, 24'(HRX));
        t_hs_ok(8, 1'b0, 24'h000004);
        t_hs_to();
        t_lp_to(24'h00000C);
        t_lp_to(24'(LTX));
        t_cont(1'b1, 10'h003);
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        t_cont(1'b0, 10'h000);
        finish_test();
    end
endmodule
`default_nettype wire

// file: rtl/lctm_monitor.sv
// Peripheral-side contention and timeout monitor for a serial display link
`timescale 1ns/1ps
`default_nettype none
module lctm_monitor (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    input  wire logic                       i_bidir,
    input  wire logic                       i_escape_en,
    input  wire logic [lctm_pkg::CNT_W-1:0] i_hs_receive_timeout,
    input  wire logic [lctm_pkg::CNT_W-1:0] i_lp_transmit_peripheral_timeout,
    input  wire logic                       i_link_clk,
    input  wire logic [1:0]                 i_lp_line,
    input  wire logic                       i_hs_active,
    input  wire logic                       i_eot,
    input  wire logic                       i_lp_tx_req,
    input  wire logic [1:0]                 i_lp_tx_drive,
    input  wire logic                       i_err_sot,
    input  wire logic                       i_err_sot_sync,
    input  wire logic                       i_err_eot_sync,
    input  wire logic                       i_err_esc,
    input  wire logic                       i_err_lp_sync,
    input  wire logic                       i_err_false,
    input  wire logic                       i_err_clear,
    output logic                            o_lp_tx_grant,
    output logic                            o_hs_rx_err,
    output logic                            o_ignore_bus,
    output logic [lctm_pkg::ERR_W-1:0]      o_err_flags,
    output logic [lctm_pkg::ERR_W-1:0]      o_err_report,
    output logic                            o_link_clk_seen
);
    // ========================================================
    // Input synchronisation
    logic [4:0] raw_in, sy;
    logic [1:0] line_s;
    logic       hs_s, eot_s, lclk_s;
    assign raw_in = {i_link_clk, i_eot, i_hs_active, i_lp_line};
    lctm_sync #(.W(5)) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   (raw_in),
        .o_q   (sy)
    );
    assign lclk_s = sy[4];
    assign eot_s  = sy[3];
    assign hs_s   = sy[2];
    assign line_s = sy[1:0];

    // ========================================================
    // Mode machine and timers
    lctm_pkg::lctm_mode_e          mode_r, mode_nxt;
    logic [lctm_pkg::CNT_W-1:0]    cnt_r, cnt_nxt;
    logic                          hs_err_r, hs_err_nxt;
    logic                          hs_receive_timeout_pend_r, hs_receive_timeout_pend_nxt;
    logic                          ltx_to_pend_r, ltx_to_pend_nxt;
    logic                          lclk_d_r, seen_r, seen_nxt;
    logic                          stop_seen, hrx_en, hrx_exp, ltx_exp;

    assign stop_seen = (line_s == lctm_pkg::LP_STOP);
    // HS receive timer enable
    assign hrx_en  = i_bidir | i_escape_en;
    assign hrx_exp = (cnt_r >= i_hs_receive_timeout);
    assign ltx_exp = (cnt_r >= i_lp_transmit_peripheral_timeout);

    always_comb begin
        mode_nxt        = mode_r;
        cnt_nxt         = cnt_r + 1'b1;
        hs_err_nxt      = 1'b0;
        hs_receive_timeout_pend_nxt = hs_receive_timeout_pend_r;
        ltx_to_pend_nxt = ltx_to_pend_r;
        seen_nxt        = lclk_s ^ lclk_d_r;
        case (mode_r)
            lctm_pkg::LCTM_IDLE: begin
                cnt_nxt = '0;
                // Timer restart on entry
                if (hs_s) begin
                    mode_nxt = lctm_pkg::LCTM_HS_RX;
                end else if (i_lp_tx_req && i_bidir) begin
                    mode_nxt = lctm_pkg::LCTM_LP_TX;
                end
            end
            lctm_pkg::LCTM_HS_RX: begin
                // Local-clock timer of HS receive
                if (eot_s || !hs_s) begin
                    // End seen; leave via stop state
                    mode_nxt = lctm_pkg::LCTM_WAIT_STOP;
                    cnt_nxt  = '0;
                end else if (hrx_en && hrx_exp) begin
                    // Expiry signalled while still in HS receive
                    hs_err_nxt      = 1'b1;
                    hs_receive_timeout_pend_nxt = 1'b1;
                    mode_nxt        = lctm_pkg::LCTM_WAIT_STOP;
                    cnt_nxt         = '0;
                end
            end
            lctm_pkg::LCTM_LP_TX: begin
                // Bus hold limit
                if (!i_lp_tx_req) begin
                    mode_nxt = lctm_pkg::LCTM_IDLE;
                    cnt_nxt  = '0;
                end else if (ltx_exp) begin
                    // Release and wait for stop
                    ltx_to_pend_nxt = 1'b1;
                    mode_nxt        = lctm_pkg::LCTM_WAIT_STOP;
                    cnt_nxt         = '0;
                end
            end
            lctm_pkg::LCTM_WAIT_STOP: begin
                cnt_nxt = '0;
                // Host stop state ends the wait
                if (stop_seen && !hs_s) begin
                    mode_nxt        = lctm_pkg::LCTM_IDLE;
                    hs_receive_timeout_pend_nxt = 1'b0;
                    ltx_to_pend_nxt = 1'b0;
                end
            end
            default: begin
                mode_nxt = lctm_pkg::LCTM_IDLE;
                cnt_nxt  = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_r        <= lctm_pkg::LCTM_IDLE;
            cnt_r         <= '0;
            hs_err_r      <= 1'b0;
            hs_receive_timeout_pend_r <= 1'b0;
            ltx_to_pend_r <= 1'b0;
            lclk_d_r      <= 1'b0;
            seen_r        <= 1'b0;
        end else begin
            mode_r        <= mode_nxt;
            cnt_r         <= cnt_nxt;
            hs_err_r      <= hs_err_nxt;
            hs_receive_timeout_pend_r <= hs_receive_timeout_pend_nxt;
            ltx_to_pend_r <= ltx_to_pend_nxt;
            lclk_d_r      <= lclk_s;
            seen_r        <= seen_nxt;
        end
    end

    // ========================================================
    // Error flags; a new event beats a clear in the same cycle
    logic [lctm_pkg::ERR_W-1:0] err_r, err_nxt, ev;
    logic                       stop_exit, drive_lp;

    // Waiting for the stop state; decoded for the exit edge and the output
    function automatic logic is_waiting(input lctm_pkg::lctm_mode_e m);
        return m == lctm_pkg::LCTM_WAIT_STOP;
    endfunction

    // We drive a level but the settled line shows another; the line lags by
    // the synchroniser, so a fault is flagged a few cycles after it starts
    function automatic logic cont_fault(
        input logic [1:0] drive,
        input logic [1:0] line,
        input logic [1:0] level
    );
        return (drive == level) && (line != level);
    endfunction

    assign stop_exit = is_waiting(mode_r) && (mode_nxt == lctm_pkg::LCTM_IDLE);
    assign drive_lp  = (mode_r == lctm_pkg::LCTM_LP_TX);

    always_comb begin
        ev = '0;
        // Start, sync and end-sync always detected
        ev[lctm_pkg::ERR_SOT]      = i_err_sot;
        ev[lctm_pkg::ERR_SOT_SYNC] = i_err_sot_sync;
        ev[lctm_pkg::ERR_EOT_SYNC] = i_err_eot_sync;
        ev[lctm_pkg::ERR_ESC]      = i_err_esc & i_escape_en;
        ev[lctm_pkg::ERR_LP_SYNC]  = i_err_lp_sync & i_escape_en;
        ev[lctm_pkg::ERR_FALSE]    = i_err_false & i_escape_en;
        // Timeout flags set only once stop state is seen
        ev[lctm_pkg::ERR_HS_RECEIVE_TIMEOUT]   = stop_exit & hs_receive_timeout_pend_r;
        ev[lctm_pkg::ERR_LTX_TO]   = stop_exit & ltx_to_pend_r;
        // Both-high and both-low contention, bidirectional lanes only
        ev[lctm_pkg::ERR_CONT_HI]  = i_bidir & drive_lp
                                     & cont_fault(i_lp_tx_drive, line_s, lctm_pkg::LP_STOP);
        ev[lctm_pkg::ERR_CONT_LO]  = i_bidir & drive_lp
                                     & cont_fault(i_lp_tx_drive, line_s, lctm_pkg::LP_BRIDGE);
        err_nxt = (i_err_clear ? lctm_pkg::ERR_RST : err_r) | ev;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            err_r <= lctm_pkg::ERR_RST;
        end else begin
            err_r <= err_nxt;
        end
    end

    // ========================================================
    // Report register; tracks the flags, the escape gate acts one cycle late
    logic [lctm_pkg::ERR_W-1:0] rep_r, rep_nxt;

    always_comb begin
        // Reporting only with escape mode
        rep_nxt = i_escape_en ? err_nxt : lctm_pkg::ERR_RST;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rep_r <= lctm_pkg::ERR_RST;
        end else begin
            rep_r <= rep_nxt;
        end
    end

    // ========================================================
    // Outputs
    assign o_lp_tx_grant   = drive_lp;
    assign o_ignore_bus    = is_waiting(mode_r);
    assign o_hs_rx_err     = hs_err_r;
    assign o_err_flags     = err_r;
    assign o_err_report    = rep_r;
    assign o_link_clk_seen = seen_r;
endmodule
`default_nettype wire

// file: rtl/lctm_pkg.sv
// Package of constants and types for the link contention timeout monitor
// Notes on behaviour
// - Escape mode: six errors reported; otherwise only start, sync, end-sync detected.
// - Contention detectors recognise both-high and both-low faults.
// - Contention fault checks apply only on bidirectional data lanes.
// - HS receive timer measures time spent in high-speed receive.
// - Missing end-of-transmission before expiry raises an error during HS receive.
// - After expiry go LP receive, ignore bus until stop state, then flag.
// - HS receive timeout active for bidirectional or escape-mode links.
// - HS receive timer may run from a local clock, not the link clock.
// - Peripheral recognises end-of-transmission and stop state, returns to LP receive.
// - Bidirectional peripheral limits its LP transmit bus hold with a timer.
// - On LP transmit expiry release bus, LP receive, wait for stop state.
// - Peripheral keeps HS receive and LP transmit timers at least.
package lctm_pkg;
    // ========================================================
    // Widths and line states
    localparam int          CNT_W      = 24;
    localparam logic [1:0]  LP_STOP    = 2'h3;
    localparam logic [1:0]  LP_HS_REQ  = 2'h1;
    localparam logic [1:0]  LP_BRIDGE  = 2'h0;
    localparam int          SYNC_W     = 3;
    // ========================================================
    // Error flag positions
    localparam int ERR_SOT      = 0;
    localparam int ERR_SOT_SYNC = 1;
    localparam int ERR_EOT_SYNC = 2;
    localparam int ERR_ESC      = 3;
    localparam int ERR_LP_SYNC  = 4;
    localparam int ERR_FALSE    = 5;
    localparam int ERR_HS_RECEIVE_TIMEOUT   = 6;
    localparam int ERR_LTX_TO   = 7;
    localparam int ERR_CONT_HI  = 8;
    localparam int ERR_CONT_LO  = 9;
    localparam int ERR_W        = 10;
    localparam logic [ERR_W-1:0] ERR_RST = 10'h000;
    // ========================================================
    // Lane modes
    typedef enum logic [2:0] {
        LCTM_IDLE,
        LCTM_HS_RX,
        LCTM_LP_TX,
        LCTM_WAIT_STOP
    } lctm_mode_e;
endpackage

// file: rtl/lctm_sync.sv
// Three-stage synchroniser with second/third agreement
`timescale 1ns/1ps
`default_nettype none
module lctm_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output var  logic [W-1:0] o_q
);
    // ========================================================
    // Stages
    logic [W-1:0] s1_r, s2_r, s3_r, q_r;
    logic [W-1:0] q_nxt;
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // A bit changes only when two settled stages agree
            always_comb begin
                q_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : q_r[g];
            end
        end
    endgenerate
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r  <= '0;
        end else begin
            s1_r <= i_d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end
    assign o_q = q_r;
endmodule
`default_nettype wire
